// ===== hw/gtgo_pkg.sv
// Purpose: Constants for the gated 16-bit counter with gate and overflow
// Assumes: AXI4-Lite register access, 32-bit data, one clock
// Notes: Byte offsets are word aligned; reserved bits read as zero, except CTRL bits 4-5, which read back as written
// What this block does
// - Two-bit select picks gate pin, companion wrap, comparator A or B.
// - With gating on, count only while polarity-adjusted gate is active.
// - Clearing counter_on stops counting and clears the toggle flip-flop.
// - Companion timer wrap from ff to 00 makes a gate pulse.
// - Each comparator source is used synchronized to counter ticks or raw.
// - Toggle flip-flop flips on rising gate edges, held clear when off.
// - One-shot: set enable, then arm; counting opens at next rising edge.
// - Arm flag clears itself on the trailing edge of that pulse.
// - Once disarmed, gate events cannot count until software rearms.
// - Toggle plus one-shot measures one full gate source period.
// - Gate level status is always readable, even with gating off.
// - Falling gate level sets gate event flag; interrupt if enabled.
// - Gate event flag is set even while gating is disabled.
// - Count wraps from ffff to 0000 and sets the overflow flag.
// - Overflow irq needs counter_on, its enable, peripheral and global.
// - In sleep, count only with external clock and sync bypass set.
// - Overflow in sleep wakes the device; irq if global enable set.
// - Secondary oscillator keeps running in sleep regardless of bypass.
// - Count is capture/compare time base; capture copies, compare matches.
// - Auto-conversion trigger clears count without setting overflow.
// - A count write in the same cycle as a trigger clear wins.
`default_nettype none
package gtgo_pkg;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_GATE = 8'h04;
	localparam logic [7:0] OFS_COUNT = 8'h08;
	localparam logic [7:0] OFS_FLAGS = 8'h0c;
	localparam logic [7:0] OFS_IRQEN = 8'h10;
	localparam logic [7:0] OFS_CCPAIR = 8'h14;
	localparam logic [7:0] OFS_CCCFG = 8'h18;
	localparam int B_ON = 0;
	localparam int B_SYNCBYP = 2;
	localparam int B_OSCEN = 3;
	localparam int B_CS = 6;
	localparam int B_GSS = 0;
	localparam int B_GVAL = 2;
	localparam int B_GO = 3;
	localparam int B_SPM = 4;
	localparam int B_TM = 5;
	localparam int B_POL = 6;
	localparam int B_GE = 7;
	localparam int B_CSYA = 8;
	localparam int B_CSYB = 9;
	localparam int B_OVF = 0;
	localparam int B_GEV = 1;
	localparam int B_OVIE = 0;
	localparam int B_GEIE = 1;
	localparam int B_PERIPHERAL_IRQ_ENABLE = 2;
	localparam int B_GIE = 3;
	localparam int B_CAP = 0;
	localparam int B_CMP = 1;
	localparam int B_ACT = 2;
	localparam logic [1:0] GSS_PIN = 2'h0;
	localparam logic [1:0] GSS_COMPANION = 2'h1;
	localparam logic [1:0] GSS_CMPA = 2'h2;
	localparam logic [1:0] GSS_CMPB = 2'h3;
	localparam logic [1:0] CS_EXT = 2'h2;
	localparam logic [7:0] COMPANION_MAX = 8'hff;
	localparam logic [15:0] COUNT_MAX = 16'hffff;
	localparam logic [31:0] RST_REG = 32'h0000_0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : gtgo_pkg
`default_nettype wire

// ===== hw/gtgo_gate.sv
// Purpose: Gate source selection, polarity, toggle and one-shot shaping
// Assumes: Pin and comparator inputs arrive already double-synchronized
// Notes: Output level is registered, one cycle behind the source, two cycles with toggle on
`default_nettype none
module gtgo_gate
	import gtgo_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [1:0] gate_source_select,
	input wire logic gate_polarity,
	input wire logic gate_toggle_enable,
	input wire logic gate_one_shot_enable,
	input wire logic gate_arm_flag,
	input wire logic counter_on,
	input wire logic cmp_a_sync,
	input wire logic cmp_b_sync,
	input wire logic tick,
	input wire logic gate_pin_s,
	input wire logic [7:0] companion_count,
	input wire logic cmp_a_s,
	input wire logic cmp_b_s,
	output logic gate_level,
	output logic arm_done
);
	typedef struct packed {
		logic [7:0] comp_prev;
		logic cmp_a_t;
		logic cmp_b_t;
		logic act_prev;
		logic tff;
		logic tg_prev;
		logic win;
		logic val;
	} gtgo_gate_st_t;
	gtgo_gate_st_t st_r, st_nxt;
	logic wrap, ca, cb, raw, act, tg, tg_rise, tg_fall;
	always_comb begin
		st_nxt = st_r;
		st_nxt.comp_prev = companion_count;
		wrap = (st_r.comp_prev == COMPANION_MAX) && (companion_count == 8'h00);
		// Synchronized variants only move on counter ticks
		if (tick) begin
			st_nxt.cmp_a_t = cmp_a_s;
			st_nxt.cmp_b_t = cmp_b_s;
		end
		ca = cmp_a_sync ? st_r.cmp_a_t : cmp_a_s;
		cb = cmp_b_sync ? st_r.cmp_b_t : cmp_b_s;
		unique case (gate_source_select)
			GSS_PIN: raw = gate_pin_s;
			GSS_COMPANION: raw = wrap;
			GSS_CMPA: raw = ca;
			GSS_CMPB: raw = cb;
		endcase
		act = ~(raw ^ gate_polarity);
		st_nxt.act_prev = act;
		if (!gate_toggle_enable || !counter_on) begin
			st_nxt.tff = 1'b0;
		end else if (act && !st_r.act_prev) begin
			st_nxt.tff = ~st_r.tff;
		end
		tg = gate_toggle_enable ? st_r.tff : act;
		st_nxt.tg_prev = tg;
		tg_rise = tg && !st_r.tg_prev;
		tg_fall = !tg && st_r.tg_prev;
		arm_done = 1'b0;
		if (!gate_one_shot_enable || !gate_arm_flag) begin
			st_nxt.win = 1'b0;
		end else if (tg_rise) begin
			st_nxt.win = 1'b1;
		end else if (tg_fall && st_r.win) begin
			st_nxt.win = 1'b0;
			arm_done = 1'b1;
		end
		st_nxt.val = gate_one_shot_enable ? (st_nxt.win && tg) : tg;
		gate_level = st_r.val;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
endmodule : gtgo_gate
`default_nettype wire

// ===== hw/gtgo_timer.sv
// Purpose: Gated 16-bit counter with overflow, gate event and compare link
// Assumes: AXI4-Lite master with one write and one read outstanding
// Notes: Flags clear by writing one; a hardware set in that cycle wins
//
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
`default_nettype none
module gtgo_timer
	import gtgo_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic gate_pin_input,
	input wire logic [7:0] companion_count,
	input wire logic comparator_a_output,
	input wire logic comparator_b_output,
	input wire logic ext_clk_input,
	input wire logic capture_input,
	input wire logic sleep_active,
	output logic irq,
	output logic wake,
	output logic compare_event,
	output logic secondary_osc_run
);
	localparam int NSYNC = 5;
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic aw_h;
		logic w_h;
		logic [ADDR_W-1:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [NSYNC-1:0] s1;
		logic [NSYNC-1:0] s2;
		logic ext_prev;
		logic cap_prev;
		logic gval_prev;
		logic [7:0] ctrl;
		logic [9:0] gate;
		logic [15:0] count;
		logic [1:0] flags;
		logic [3:0] irqen;
		logic [15:0] ccpair;
		logic [2:0] cccfg;
		logic trig;
		logic irq;
		logic wake;
		logic cmp_ev;
		logic match_prev;
		logic osc_run;
	} gtgo_st_t;
	gtgo_st_t st_r, st_nxt;
	logic gate_level, arm_done;
	logic on, gen, syncbyp, tick, count_en, ext_rise, cap_rise, match;
	logic [1:0] cs;
	logic wr_do, wr_ok, rd_ok, ovf_set, gev_set;
	logic [31:0] wmask, rd_val;
	logic [15:0] cnt_inc;
	gtgo_gate u_gate (
		.aclk(aclk),
		.aresetn(aresetn),
		.gate_source_select(st_r.gate[B_GSS+:2]),
		.gate_polarity(st_r.gate[B_POL]),
		.gate_toggle_enable(st_r.gate[B_TM]),
		.gate_one_shot_enable(st_r.gate[B_SPM]),
		.gate_arm_flag(st_r.gate[B_GO]),
		.counter_on(st_r.ctrl[B_ON]),
		.cmp_a_sync(st_r.gate[B_CSYA]),
		.cmp_b_sync(st_r.gate[B_CSYB]),
		.tick(tick),
		.gate_pin_s(st_r.s2[0]),
		.companion_count(companion_count),
		.cmp_a_s(st_r.s2[1]),
		.cmp_b_s(st_r.s2[2]),
		.gate_level(gate_level),
		.arm_done(arm_done)
	);
	// Merge written bytes into an old value
	function automatic logic [31:0] gtgo_merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [31:0] m);
		gtgo_merge = (old & ~m) | (nw & m);
	endfunction : gtgo_merge
	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = {capture_input, ext_clk_input, comparator_b_output,
			comparator_a_output, gate_pin_input};
		st_nxt.s2 = st_r.s1;
		st_nxt.ext_prev = st_r.s2[3];
		st_nxt.cap_prev = st_r.s2[4];
		ext_rise = st_r.s2[3] && !st_r.ext_prev;
		cap_rise = st_r.s2[4] && !st_r.cap_prev;
		on = st_r.ctrl[B_ON];
		syncbyp = st_r.ctrl[B_SYNCBYP];
		cs = st_r.ctrl[B_CS+:2];
		gen = st_r.gate[B_GE];
		// Internal sources tick every cycle; no separate slow oscillator here
		tick = (cs == CS_EXT) ? ext_rise : 1'b1;
		if (sleep_active && !((cs == CS_EXT) && syncbyp)) begin
			tick = 1'b0;
		end
		count_en = on && (!gen || gate_level) && tick;
		cnt_inc = st_r.count + 16'h0001;
		// A trigger clear is not a wrap, so it must not raise overflow
		ovf_set = count_en && !st_r.trig
			&& (st_r.count == COUNT_MAX);
		st_nxt.gval_prev = gate_level;
		gev_set = st_r.gval_prev && !gate_level;
		match = st_r.cccfg[B_CMP] && (st_r.ccpair == st_r.count);
		// Only the start of a match fires, even if the count stays parked
		st_nxt.match_prev = match;
		st_nxt.cmp_ev = match && !st_r.match_prev;
		st_nxt.trig = match && st_r.cccfg[B_ACT] && !st_r.match_prev;
		// Count path: write beats trigger beats increment
		if (st_r.trig) begin
			st_nxt.count = 16'h0000;
		end else if (count_en) begin
			st_nxt.count = cnt_inc;
		end
		if (st_r.cccfg[B_CAP] && cap_rise) begin
			st_nxt.ccpair = st_r.count;
		end
		if (arm_done) begin
			st_nxt.gate[B_GO] = 1'b0;
		end
		st_nxt.gate[B_GVAL] = 1'b0;
		// AXI write channel
		if (s_axi_awvalid && st_r.awready) begin
			st_nxt.aw_h = 1'b1;
			st_nxt.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && st_r.wready) begin
			st_nxt.w_h = 1'b1;
			st_nxt.wdata = s_axi_wdata;
			st_nxt.wstrb = s_axi_wstrb;
		end
		if (st_r.bvalid && s_axi_bready) begin
			st_nxt.bvalid = 1'b0;
		end
		wr_do = st_r.aw_h && st_r.w_h && !st_r.bvalid;
		for (int i = 0; i < 4; i++) begin
			wmask[i*8+:8] = {8{st_r.wstrb[i]}};
		end
		wr_ok = 1'b1;
		if (wr_do) begin
			st_nxt.aw_h = 1'b0;
			st_nxt.w_h = 1'b0;
			st_nxt.bvalid = 1'b1;
			unique case (st_r.awaddr)
				OFS_CTRL: st_nxt.ctrl = 8'(gtgo_merge(32'(st_r.ctrl),
					st_r.wdata, wmask) & 32'h0000_00fd);
				OFS_GATE: begin
					st_nxt.gate = 10'(gtgo_merge(32'(st_r.gate),
						st_r.wdata, wmask));
					st_nxt.gate[B_GVAL] = 1'b0;
					if (!wmask[B_GO]) begin
						st_nxt.gate[B_GO] = st_nxt.gate[B_GO] && !arm_done;
					end
				end
				OFS_COUNT: st_nxt.count = 16'(gtgo_merge(32'(st_r.count),
					st_r.wdata, wmask));
				OFS_FLAGS: st_nxt.flags = st_r.flags
					& ~(st_r.wdata[1:0] & wmask[1:0]);
				OFS_IRQEN: st_nxt.irqen = 4'(gtgo_merge(32'(st_r.irqen),
					st_r.wdata, wmask));
				OFS_CCPAIR: st_nxt.ccpair = 16'(gtgo_merge(32'(st_r.ccpair),
					st_r.wdata, wmask));
				OFS_CCCFG: st_nxt.cccfg = 3'(gtgo_merge(32'(st_r.cccfg),
					st_r.wdata, wmask));
				default: wr_ok = 1'b0;
			endcase
			st_nxt.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
		end
		// Hardware sets win over a same-cycle software clear
		if (ovf_set) begin
			st_nxt.flags[B_OVF] = 1'b1;
		end
		if (gev_set) begin
			st_nxt.flags[B_GEV] = 1'b1;
		end
		st_nxt.awready = !st_nxt.aw_h && !st_nxt.bvalid;
		st_nxt.wready = !st_nxt.w_h && !st_nxt.bvalid;
		// AXI read channel
		rd_ok = 1'b1;
		rd_val = 32'h0000_0000;
		unique case (s_axi_araddr)
			OFS_CTRL: rd_val = 32'(st_r.ctrl);
			OFS_GATE: begin
				rd_val = 32'(st_r.gate);
				rd_val[B_GVAL] = gate_level;
			end
			OFS_COUNT: rd_val = 32'(st_r.count);
			OFS_FLAGS: rd_val = 32'(st_r.flags);
			OFS_IRQEN: rd_val = 32'(st_r.irqen);
			OFS_CCPAIR: rd_val = 32'(st_r.ccpair);
			OFS_CCCFG: rd_val = 32'(st_r.cccfg);
			default: rd_ok = 1'b0;
		endcase
		if (s_axi_arvalid && st_r.arready) begin
			st_nxt.arready = 1'b0;
			st_nxt.rvalid = 1'b1;
			st_nxt.rdata = rd_ok ? rd_val : 32'h0000_0000;
			st_nxt.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (st_r.rvalid && s_axi_rready) begin
			st_nxt.rvalid = 1'b0;
			st_nxt.arready = 1'b1;
		end
		// Interrupt and wake outputs follow the registered flags
		st_nxt.irq = st_r.irqen[B_GIE] && st_r.irqen[B_PERIPHERAL_IRQ_ENABLE]
			&& ((st_r.flags[B_OVF] && st_r.irqen[B_OVIE] && on)
			|| (st_r.flags[B_GEV] && st_r.irqen[B_GEIE]));
		// Wake does not need the global enable; handler entry does
		st_nxt.wake = sleep_active && st_r.flags[B_OVF] && on
			&& st_r.irqen[B_OVIE] && st_r.irqen[B_PERIPHERAL_IRQ_ENABLE];
		st_nxt.osc_run = st_r.ctrl[B_OSCEN];
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= '0;
			st_r.awready <= 1'b1;
			st_r.wready <= 1'b1;
			st_r.arready <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign s_axi_awready = st_r.awready;
	assign s_axi_wready = st_r.wready;
	assign s_axi_bresp = st_r.bresp;
	assign s_axi_bvalid = st_r.bvalid;
	assign s_axi_arready = st_r.arready;
	assign s_axi_rdata = st_r.rdata;
	assign s_axi_rresp = st_r.rresp;
	assign s_axi_rvalid = st_r.rvalid;
	assign irq = st_r.irq;
	assign wake = st_r.wake;
	assign compare_event = st_r.cmp_ev;
	assign secondary_osc_run = st_r.osc_run;
endmodule : gtgo_timer
`default_nettype wire

// ===== verif/gtgo_timer_properties.sv
// Purpose: Port-level checks of the gated counter bus and events
// Assumes: One clock, synchronous active-low reset
// Notes: Register state is unseen here, so the bench checks it
`default_nettype none
module gtgo_timer_properties
	import gtgo_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic compare_event
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	property p_b_answer;
		s_wr_take |-> ##[1:2] s_axi_bvalid;
	endproperty
	property p_r_answer;
		s_rd_take |-> ##[1:2] s_axi_rvalid;
	endproperty
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
	endproperty
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	property p_aw_block;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	property p_ar_block;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	property p_w_reopen;
		s_axi_bvalid && s_axi_bready |=> s_axi_awready && s_axi_wready;
	endproperty
	property p_resp;
		s_axi_bvalid |-> s_axi_bresp == RESP_OKAY || s_axi_bresp == RESP_SLVERR;
	endproperty
	property p_cmp_pulse;
		compare_event |=> !compare_event;
	endproperty
	a_b_answer: assert property (p_b_answer) else $error("late bvalid");
	a_r_answer: assert property (p_r_answer) else $error("late rvalid");
	a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
	a_r_hold: assert property (p_r_hold) else $error("read data moved");
	a_aw_block: assert property (p_aw_block) else $error("write reopened");
	a_ar_block: assert property (p_ar_block) else $error("read reopened");
	a_w_reopen: assert property (p_w_reopen) else $error("write stuck");
	a_resp: assert property (p_resp) else $error("bad bresp");
	a_cmp_pulse: assert property (p_cmp_pulse) else $error("long match");
endmodule : gtgo_timer_properties
bind gtgo_timer gtgo_timer_properties u_gtgo_timer_properties (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .compare_event(compare_event));
`default_nettype wire

// ===== verif/gtgo_far_side.sv
// Purpose: Far side: gate pin, comparators and companion timer
// Assumes: Bench sets pin and comparator levels
// Notes: Companion runs on aclk, so its wrap pulse is same-clock
`default_nettype none
module gtgo_far_side (
	input wire logic aclk,
	input wire logic pin,
	input wire logic cmp,
	input wire logic run,
	output logic gate_pin_input,
	output logic [7:0] companion_count,
	output logic comparator_a_output,
	output logic comparator_b_output,
	output logic ext_clk_input,
	output logic capture_input
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] cnt_r = 8'h00;
	assign gate_pin_input = pin;
	assign comparator_a_output = cmp;
	assign comparator_b_output = ~cmp;
	assign capture_input = cmp;
	assign companion_count = cnt_r;
	assign ext_clk_input = cnt_r[0];
	// Wraps ff to 00 once per lap, giving one gate pulse
	always @(posedge aclk)
		if (run) cnt_r <= cnt_r + 8'h01;
endmodule : gtgo_far_side
`default_nettype wire

// ===== verif/tb.sv
// Purpose: Self-checking bench for the gated counter
// Assumes: Bus tasks own the AXI inputs; far-side model drives pins
// Notes: Exact counts are checked only while counting is held
`default_nettype none
module tb
	import gtgo_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awa, ara, cc;
	logic awv, wv, bry, arv, rry, pin, cmp, run, slp;
	logic awr, wrd, bv, arr, rv, irq, cev, gp, ca, cb, ek, cap;
	logic wk, osr;
	logic [31:0] wd, rdd;
	logic [31:0] seed = 32'h26e2e5ed;
	logic [3:0] ws;
	logic [1:0] br, rr;
	logic [33:0] exq[$];
	int err_count = 0;
	int comparisons = 0;
	always #20 aclk = ~aclk;
	gtgo_far_side u_gtgo_far_side (.aclk(aclk), .pin(pin), .cmp(cmp),
		.run(run), .gate_pin_input(gp), .companion_count(cc),
		.comparator_a_output(ca), .comparator_b_output(cb),
		.ext_clk_input(ek), .capture_input(cap));
	gtgo_timer u_gtgo_timer (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
		.s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv),
		.s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdd), .s_axi_rresp(rr),
		.s_axi_rvalid(rv), .s_axi_rready(rry), .gate_pin_input(gp),
		.companion_count(cc), .comparator_a_output(ca),
		.comparator_b_output(cb), .ext_clk_input(ek),
		.capture_input(cap), .sleep_active(slp), .irq(irq), .wake(wk),
		.compare_event(cev), .secondary_osc_run(osr));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic report_and_stop();
		$display("comparisons %0d errors %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : report_and_stop
	task automatic chk(input string nm, input logic [33:0] seen,
		input logic [33:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask : cyc
	// Held ready lines mean one write and one read at most in flight
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r = RESP_OKAY);
		logic ta, tw, tk;
		exq.push_back({r, 32'h0});
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		do begin
			@(negedge aclk);
			ta = awv & awr;
			tw = wv & wrd;
			tk = bv & bry;
			@(posedge aclk);
			if (ta) awv <= 1'b0;
			if (tw) wv <= 1'b0;
		end while (!tk);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		logic ta, tk;
		exq.push_back(e);
		ara <= a;
		arv <= 1'b1;
		do begin
			@(negedge aclk);
			ta = arv & arr;
			tk = rv & rry;
			@(posedge aclk);
			if (ta) arv <= 1'b0;
		end while (!tk);
	endtask : rd
	always @(negedge aclk) begin
		if (bv && bry)
			chk("bresp", {br, 32'h0}, exq.pop_front());
		if (rv && rry)
			chk("read", {rr, rdd}, exq.pop_front());
	end
	initial begin
		repeat (20000) @(posedge aclk);
		err_count++;
		report_and_stop();
	end
	initial begin
		{awv, wv, arv, pin, cmp, run, slp} = '0;
		{bry, rry} = 2'h3;
		{awa, ara, wd} = '0;
		ws = 4'hf;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		run <= 1'b1;
		rd(OFS_CTRL, 34'h0);
		rd(8'h1c, {RESP_SLVERR, 32'h0});
		wr(8'h20, 32'hffff_ffff, RESP_SLVERR);
		for (int i = 0; i < 3; i++) begin
			seed = lfsr(seed);
			wr(OFS_COUNT, seed);
			rd(OFS_COUNT, {RESP_OKAY, 16'h0, seed[15:0]});
		end
		wr(OFS_GATE, 32'hc0);
		wr(OFS_CTRL, 32'h1);
		cyc(8);
		rd(OFS_COUNT, {RESP_OKAY, 16'h0, seed[15:0]});
		wr(OFS_CTRL, 32'h0);
		wr(OFS_GATE, 32'h40);
		wr(OFS_FLAGS, 32'h3);
		pin <= 1'b1;
		cyc(8);
		rd(OFS_GATE, {RESP_OKAY, 32'h44});
		pin <= 1'b0;
		cyc(8);
		rd(OFS_FLAGS, {RESP_OKAY, 32'h2});
		for (int s = 1; s < 4; s++) begin
			wr(OFS_FLAGS, 32'h3);
			wr(OFS_GATE, 32'h40 | s | (s == 2 ? 32'h100 : 32'h0));
			cmp <= ~cmp;
			cyc(8);
			cmp <= ~cmp;
			cyc(300);
			rd(OFS_FLAGS, {RESP_OKAY, 32'h2});
		end
		// Polarity stays set; one-shot alone first, then with toggle on
		wr(OFS_GATE, 32'hd0);
		wr(OFS_COUNT, 32'h0);
		wr(OFS_CTRL, 32'h1);
		wr(OFS_GATE, 32'hd8);
		for (int k = 0; k < 2; k++) begin
			pin <= 1'b1;
			cyc(10);
			pin <= 1'b0;
			cyc(10);
		end
		rd(OFS_GATE, {RESP_OKAY, 32'hd0});
		rd(OFS_COUNT, {RESP_OKAY, 32'h0000_000a});
		wr(OFS_GATE, 32'hf0);
		wr(OFS_COUNT, 32'h0);
		wr(OFS_GATE, 32'hf8);
		for (int k = 0; k < 3; k++) begin
			pin <= 1'b1;
			cyc(6);
			pin <= 1'b0;
			cyc(4);
		end
		rd(OFS_COUNT, {RESP_OKAY, 32'h0000_000a});
		wr(OFS_GATE, 32'h40);
		wr(OFS_CTRL, 32'h0);
		// Flags cleared before any interrupt enable
		wr(OFS_FLAGS, 32'h3);
		wr(OFS_COUNT, 32'hffff);
		wr(OFS_CTRL, 32'h1);
		cyc(4);
		wr(OFS_CTRL, 32'h0);
		rd(OFS_FLAGS, {RESP_OKAY, 32'h1});
		wr(OFS_IRQEN, 32'hd);
		cyc(3);
		chk("irq", {33'h0, irq}, 34'h0);
		wr(OFS_CTRL, 32'h1);
		cyc(3);
		chk("irq", {33'h0, irq}, 34'h1);
		wr(OFS_FLAGS, 32'h1);
		cyc(3);
		chk("irq", {33'h0, irq}, 34'h0);
		wr(OFS_IRQEN, 32'h0);
		// Asleep: no count without bypass; overflow then wakes
		slp <= 1'b1;
		wr(OFS_FLAGS, 32'h3);
		wr(OFS_COUNT, 32'hffff);
		wr(OFS_CTRL, 32'h89);
		cyc(10);
		rd(OFS_FLAGS, {RESP_OKAY, 32'h0});
		chk("osc", {33'h0, osr}, 34'h1);
		wr(OFS_IRQEN, 32'h5);
		wr(OFS_CTRL, 32'h8d);
		cyc(10);
		chk("wake", {33'h0, wk}, 34'h1);
		chk("irq", {33'h0, irq}, 34'h0);
		slp <= 1'b0;
		wr(OFS_IRQEN, 32'h0);
		wr(OFS_CTRL, 32'h0);
		wr(OFS_COUNT, 32'h0);
		wr(OFS_CCPAIR, 32'h20);
		wr(OFS_CCCFG, 32'h6);
		wr(OFS_FLAGS, 32'h3);
		// Internal clock keeps every trigger seen
		wr(OFS_CTRL, 32'h1);
		for (int i = 0; i < 100 && cev !== 1'b1; i++)
			@(negedge aclk);
		chk("compare", {33'h0, cev}, 34'h1);
		cyc(200);
		wr(OFS_CTRL, 32'h0);
		rd(OFS_FLAGS, {RESP_OKAY, 32'h0});
		wr(OFS_CCCFG, 32'h1);
		wr(OFS_COUNT, {16'h0, seed[31:16]});
		cmp <= 1'b1;
		cyc(8);
		rd(OFS_CCPAIR, {RESP_OKAY, 16'h0, seed[31:16]});
		report_and_stop();
	end
endmodule : tb
`default_nettype wire
